// ---- common/frc_pkg.sv ----
// Shared constants, types and register map of the protocol controller test and init block.
package frc_pkg;

  // Register port widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] OFS_CMD      = 8'h00;
  localparam logic [7:0] OFS_TEST_ONE = 8'h04;
  localparam logic [7:0] OFS_TEST_TWO = 8'h08;
  localparam logic [7:0] OFS_MH_STAT  = 8'h0c;
  localparam logic [7:0] OFS_TX_PEND  = 8'h10;
  localparam logic [7:0] OFS_TX_REQ   = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
  localparam logic [7:0] OFS_TRIG_SEL = 8'h20;
  localparam logic [7:0] OFS_RAM_ADDR = 8'h24;
  localparam logic [7:0] OFS_RAM_DATA = 8'h28;

  // Field positions.
  localparam int CMD_LSB         = 0;
  localparam int TR1_TEST_WRITE_ENABLE_BIT   = 0;
  localparam int TR1_TMC_LSB     = 4;
  localparam int TR1_LOOP_BIT    = 8;
  localparam int TR1_ATM_BIT     = 9;
  localparam int TR1_CERR_LSB    = 16;
  localparam int TR2_ECC_WRITE_TEST_BIT_BIT   = 14;
  localparam int MHS_BUSY_BIT    = 7;

  // Command codes.
  localparam logic [3:0] CMD_RAM_CLEAR = 4'hc;

  // Interrupt status layout.
  localparam int IRQ_W       = 3;
  localparam int IRQ_TX_DONE = 0;
  localparam int IRQ_RAM_DONE = 1;
  localparam int IRQ_CODE_ERR = 2;

  // Reset values.
  localparam logic [31:0] RST_TEST_ONE = 32'h0000_0000;
  localparam logic [31:0] RST_TEST_TWO = 32'h0000_0000;
  localparam logic [2:0]  RST_IRQ_MASK = 3'h0;
  localparam logic        RST_TRIG_SEL = 1'b0;

  // Timing: one clock serves as module and bank clock.
  localparam int CLK_PERIOD_NS    = 50;
  localparam int RAM_CLEAR_EXTRA  = 1;

  // Observation trigger field widths.
  localparam int SLOT_W = 11;
  localparam int TB_W   = 5;

  typedef enum logic [1:0] {
    CERR_NONE = 2'b00,
    CERR_CRC  = 2'b01,
    CERR_FES  = 2'b10
  } frc_cerr_t;

  typedef enum logic [1:0] {
    TMC_NORMAL   = 2'b00,
    TMC_RAM_TEST = 2'b01,
    TMC_IO_TEST  = 2'b10,
    TMC_RESERVED = 2'b11
  } frc_tmc_t;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_BUSY = 1'b1
  } frc_tx_state_t;

  typedef struct packed {
    logic done;
    logic crcErr;
    logic fesErr;
  } frc_rx_status_t;

  typedef struct packed {
    logic                     valid;
    logic [SLOT_W+TB_W-1:0]   data;
  } frc_trig_t;

endpackage

// ---- hdl/frc_ctrl_top.sv ----
// Top of the protocol controller test, RAM init, interrupt and trigger logic.
// What this block does
// - Frame with CRC and end-sequence errors reports the decoding error.
// - Async transmit, loop back, RAM test and I/O test modes are selectable.
// - RAM-clear command writes one defined value into every RAM location.
// - For line zero and one flags, a set beats a same-cycle clear.
// - Interrupt requests only on a flag's zero-to-one transition.
// - The ECC write test bit ignores writes and rests at zero.
// - Trigger valid follows slot and buffer changes; only data is gated.
// - RAM clear after reset or command 1100 lasts 2049 cycles, busy falls.
`timescale 1ns/1ps
module frc_ctrl_top
  import frc_pkg::*;
#(
  parameter int RAM_DEPTH = 2048,
  parameter int RAM_W     = 16,
  parameter int NBUF      = 32
) (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic [ADDR_W-1:0]         regAddr,
  input  wire logic [DATA_W-1:0]         regWdata,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output logic [DATA_W-1:0]              regRdata,
  input  wire frc_rx_status_t            rxStatus,
  input  wire logic                      txDone,
  input  wire logic [SLOT_W-1:0]         slotCounter,
  input  wire logic [TB_W-1:0]           tbState,
  output logic                           txStart,
  output logic [$clog2(NBUF)-1:0]        txBufIndex,
  output logic                           loopBackEn,
  output logic                           asyncTxEn,
  output logic [1:0]                     testMux,
  output logic                           ramClearActive,
  output logic                           irq,
  output logic                           irqLineZero,
  output logic                           irqLineOne,
  output frc_trig_t                      trigBusTwo
);
  localparam int AW = $clog2(RAM_DEPTH);
  localparam int IW = $clog2(NBUF);

  // Refuse shapes that the register layout, the address index or the sweep checks cannot serve.
  generate
    if (RAM_DEPTH < 8 || (RAM_DEPTH & (RAM_DEPTH - 1)) != 0 || RAM_W > DATA_W ||
        NBUF < 2 || NBUF > DATA_W) begin : g_bad_param
      $error("frc_ctrl_top: unsupported RAM_DEPTH, RAM_W or NBUF");
    end
  endgenerate

  // Lowest pending buffer wins the next transmission slot.
  function automatic logic [IW-1:0] lowestSet(input logic [NBUF-1:0] v);
    logic [IW-1:0] idx;
    idx = '0;
    for (int k = NBUF - 1; k >= 0; k--) begin
      if (v[k]) begin
        idx = IW'(k);
      end
    end
    return idx;
  endfunction

  // Address match used by both strobes.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  logic [DATA_W-1:0]  testOne;
  logic [DATA_W-1:0]  testTwo;
  logic [IRQ_W-1:0]   irqMask;
  logic               trigSel;
  logic [AW-1:0]      ramAddr;
  logic [RAM_W-1:0]   mem [RAM_DEPTH];
  logic [NBUF-1:0]    pend;
  frc_tx_state_t      txState;
  logic [IW-1:0]      curBuf;
  frc_cerr_t          codeErr;
  logic [SLOT_W-1:0]  prevSlot;
  logic [TB_W-1:0]    prevTb;
  logic               txDoneEv;
  logic [IRQ_W-1:0]   irqStatus;
  logic [IRQ_W-1:0]   irqReq;
  logic               clrBusy;
  logic               clrWe;
  logic [AW-1:0]      clrAddr;
  logic               clrDone;

  // Write decode.
  wire wrCmd    = regWr && hit(regAddr, OFS_CMD);
  wire wrTest1  = regWr && hit(regAddr, OFS_TEST_ONE);
  wire wrTest2  = regWr && hit(regAddr, OFS_TEST_TWO);
  wire wrTxReq  = regWr && hit(regAddr, OFS_TX_REQ);
  wire wrIrqSt  = regWr && hit(regAddr, OFS_IRQ_STAT);
  wire wrIrqMk  = regWr && hit(regAddr, OFS_IRQ_MASK);
  wire wrSel    = regWr && hit(regAddr, OFS_TRIG_SEL);
  wire wrRamA   = regWr && hit(regAddr, OFS_RAM_ADDR);
  wire wrRamD   = regWr && hit(regAddr, OFS_RAM_DATA);
  wire clrStart = wrCmd && (regWdata[CMD_LSB +: 4] == CMD_RAM_CLEAR);
  wire [IW-1:0] reqIdx = regWdata[IW-1:0];
  wire [IRQ_W-1:0] irqClr = wrIrqSt ? regWdata[IRQ_W-1:0] : '0;

  // Software RAM writes need the test write enable; the sweep overrides them.
  wire swRamWe = wrRamD && testOne[TR1_TEST_WRITE_ENABLE_BIT] && !clrBusy;

  // Test mode controls come straight from the first test register.
  assign loopBackEn = testOne[TR1_LOOP_BIT];
  assign asyncTxEn  = testOne[TR1_ATM_BIT];
  assign testMux    = testOne[TR1_TMC_LSB +: 2];
  assign ramClearActive = clrBusy;

  // Control registers; the ECC write test bit is never stored.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      testOne <= RST_TEST_ONE;
      testTwo <= RST_TEST_TWO;
      irqMask <= RST_IRQ_MASK;
      trigSel <= RST_TRIG_SEL;
      ramAddr <= '0;
    end else begin
      if (wrTest1) begin
        testOne <= regWdata;
      end
      if (wrTest2) begin
        testTwo <= regWdata & ~(DATA_W'(1) << TR2_ECC_WRITE_TEST_BIT_BIT);
      end
      if (wrIrqMk) begin
        irqMask <= regWdata[IRQ_W-1:0];
      end
      if (wrSel) begin
        trigSel <= regWdata[0];
      end
      if (wrRamA) begin
        ramAddr <= regWdata[AW-1:0];
      end
    end
  end

  // RAM storage: the clear sweep writes zero, software writes in test.
  always_ff @(posedge clk) begin
    if (clrWe) begin
      mem[clrAddr] <= '0;
    end else if (swRamWe) begin
      mem[ramAddr] <= regWdata[RAM_W-1:0];
    end
  end

  // Transmission scheduler; pending bits hold until the link reports done.
  assign txDoneEv = (txState == TX_BUSY) && txDone;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend       <= '0;
      txState    <= TX_IDLE;
      curBuf     <= '0;
      txStart    <= 1'b0;
      txBufIndex <= '0;
    end else begin
      txStart <= 1'b0;
      unique case (txState)
        TX_IDLE: begin
          if ((|pend) && !clrBusy) begin
            curBuf     <= lowestSet(pend);
            txBufIndex <= lowestSet(pend);
            txStart    <= 1'b1;
            txState    <= TX_BUSY;
          end
        end
        TX_BUSY: begin
          if (txDone) begin
            txState <= TX_IDLE;
          end
        end
      endcase
      for (int b = 0; b < NBUF; b++) begin
        if (wrTxReq && reqIdx == IW'(b)) begin
          pend[b] <= 1'b1;
        end else if (txDoneEv && curBuf == IW'(b)) begin
          pend[b] <= 1'b0;
        end
      end
    end
  end

  // Coding error capture; the end-sequence error takes precedence.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      codeErr <= CERR_NONE;
    end else if (rxStatus.done) begin
      codeErr <= rxStatus.fesErr ? CERR_FES :
                 rxStatus.crcErr ? CERR_CRC : CERR_NONE;
    end
  end
  wire codeErrEv = rxStatus.done && (rxStatus.fesErr || rxStatus.crcErr);

  // Trigger valid ignores the selection; the data is gated by it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prevSlot   <= '0;
      prevTb     <= '0;
      trigBusTwo <= '0;
    end else begin
      prevSlot         <= slotCounter;
      prevTb           <= tbState;
      trigBusTwo.valid <= (slotCounter != prevSlot) || (tbState != prevTb);
      trigBusTwo.data  <= trigSel ? {slotCounter, tbState} : '0;
    end
  end

  frc_ram_clear #(
    .RAM_DEPTH (RAM_DEPTH)
  ) u_clear (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (clrStart),
    .busy    (clrBusy),
    .clrWe   (clrWe),
    .clrAddr (clrAddr),
    .done    (clrDone)
  );

  frc_irq_flags u_irq (
    .clk     (clk),
    .sys_rst (sys_rst),
    .setEv   ({codeErrEv, clrDone, txDoneEv}),
    .clrBits (irqClr),
    .mask    (irqMask),
    .status  (irqStatus),
    .request (irqReq),
    .irq     (irq)
  );

  // Line requests are the edge pulses of their flags, one cycle late.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqLineZero <= 1'b0;
      irqLineOne  <= 1'b0;
    end else begin
      irqLineZero <= irqReq[IRQ_TX_DONE];
      irqLineOne  <= irqReq[IRQ_RAM_DONE];
    end
  end

  // Read selection; unmapped addresses read zero.
  wire [DATA_W-1:0] rdTest1 = {testOne[DATA_W-1:TR1_CERR_LSB+2], codeErr,
                               testOne[TR1_CERR_LSB-1:0]};
  wire [DATA_W-1:0] rdMhs   = DATA_W'(clrBusy) << MHS_BUSY_BIT;
  wire [DATA_W-1:0] readWord =
    hit(regAddr, OFS_TEST_ONE) ? rdTest1 :
    hit(regAddr, OFS_TEST_TWO) ? testTwo :
    hit(regAddr, OFS_MH_STAT)  ? rdMhs :
    hit(regAddr, OFS_TX_PEND)  ? DATA_W'(pend) :
    hit(regAddr, OFS_IRQ_STAT) ? DATA_W'(irqStatus) :
    hit(regAddr, OFS_IRQ_MASK) ? DATA_W'(irqMask) :
    hit(regAddr, OFS_TRIG_SEL) ? DATA_W'(trigSel) :
    hit(regAddr, OFS_RAM_ADDR) ? DATA_W'(ramAddr) :
    hit(regAddr, OFS_RAM_DATA) ? DATA_W'(mem[ramAddr]) : '0;

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdata <= '0;
    end else begin
      regRdata <= regRd ? readWord : '0;
    end
  end

  sequence txLaunch;
    txStart ##1 (txState == TX_BUSY);
  endsequence

  chk_code_prec: assert property (@(posedge clk) disable iff (sys_rst)
    (rxStatus.done && rxStatus.fesErr && rxStatus.crcErr) |=> (codeErr == CERR_FES))
    else $error("CRC error reported over decoding error");

  chk_ecc_write_test_bit_zero: assert property (@(posedge clk) disable iff (sys_rst)
    wrTest2 |=> !testTwo[TR2_ECC_WRITE_TEST_BIT_BIT])
    else $error("ECC write test bit stored a write");

  chk_trig_valid: assert property (@(posedge clk) disable iff (sys_rst)
    (!trigSel && !$past(sys_rst) && $changed(slotCounter)) |=>
      trigBusTwo.valid && (trigBusTwo.data == '0))
    else $error("Trigger valid gated or data leaked");

  chk_pend_set: assert property (@(posedge clk) disable iff (sys_rst)
    wrTxReq |=> pend[$past(reqIdx)])
    else $error("Pending bit not set by request");

  chk_pend_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (txDoneEv && !(wrTxReq && reqIdx == curBuf)) |=> !pend[$past(curBuf)])
    else $error("Pending bit not cleared at completion");

  chk_tx_launch: assert property (@(posedge clk) disable iff (sys_rst)
    txStart |-> pend[txBufIndex] ##0 txLaunch)
    else $error("Launch without a pending buffer");

  chk_clear_fill: assert property (@(posedge clk) disable iff (sys_rst)
    (clrWe && clrAddr == ramAddr) |=> (mem[ramAddr] == '0) || $changed(ramAddr))
    else $error("Clear sweep left a location unwritten");

  chk_line_pulse: assert property (@(posedge clk) disable iff (sys_rst)
    irqLineZero |=> !irqLineZero)
    else $error("Line zero request longer than one cycle");

  chk_clear_cmd: assert property (@(posedge clk) disable iff (sys_rst)
    (clrStart && !clrBusy) |=> clrBusy [*8])
    else $error("Clear command did not start the sweep");
endmodule

// ---- hdl/frc_irq_flags.sv ----
// Sticky interrupt flags with set-over-clear, edge requests and a masked level output.
`timescale 1ns/1ps
module frc_irq_flags
  import frc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [IRQ_W-1:0] setEv,
  input  wire logic [IRQ_W-1:0] clrBits,
  input  wire logic [IRQ_W-1:0] mask,
  output logic [IRQ_W-1:0]      status,
  output logic [IRQ_W-1:0]      request,
  output logic                  irq
);
  logic [IRQ_W-1:0] next_status;

  // A set in the clearing cycle keeps the flag set.
  genvar i;
  generate
    for (i = 0; i < IRQ_W; i++) begin : g_flag
      assign next_status[i] = setEv[i] | (status[i] & ~clrBits[i]);
    end
  endgenerate

  // Requests fire only on a zero-to-one step of a flag.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status  <= '0;
      request <= '0;
      irq     <= 1'b0;
    end else begin
      status  <= next_status;
      request <= next_status & ~status;
      irq     <= |(next_status & mask);
    end
  end

  chk_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
    (setEv[IRQ_TX_DONE] && clrBits[IRQ_TX_DONE]) |=> status[IRQ_TX_DONE])
    else $error("Clear beat a simultaneous set");

  chk_edge_only: assert property (@(posedge clk) disable iff (sys_rst)
    (status[IRQ_TX_DONE] && setEv[IRQ_TX_DONE]) |=> !request[IRQ_TX_DONE])
    else $error("Request produced for a flag that stayed set");
endmodule

// ---- hdl/frc_ram_clear.sv ----
// RAM clear sequencer: sweeps every location and holds busy for depth plus one cycles.
`timescale 1ns/1ps
module frc_ram_clear
  import frc_pkg::*;
#(
  parameter int RAM_DEPTH = 2048
) (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         start,
  output logic                              busy,
  output logic                              clrWe,
  output logic [$clog2(RAM_DEPTH)-1:0]      clrAddr,
  output logic                              done
);
  localparam int CYCLES = RAM_DEPTH + RAM_CLEAR_EXTRA;
  localparam int CW = $clog2(CYCLES + 1);
  localparam int AW = $clog2(RAM_DEPTH);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(RAM_DEPTH);

  logic [CW-1:0] cnt;
  logic [CW-1:0] helpCnt;

  // Reset itself launches a clear; a command launches one only when idle.
  always_ff @(posedge clk) begin
    if (sys_rst || (start && !busy)) begin
      busy <= 1'b1;
      cnt  <= '0;
      done <= 1'b0;
    end else if (busy) begin
      cnt  <= cnt + 1'b1;
      busy <= (cnt != LAST);
      done <= (cnt == LAST);
    end else begin
      done <= 1'b0;
    end
  end

  // Every location gets the defined value zero once per sweep.
  assign clrWe   = busy && (cnt < DEPTH_C);
  assign clrAddr = cnt[AW-1:0];

  // Helper count of busy cycles for the duration check.
  always_ff @(posedge clk) begin
    if (sys_rst || !busy) begin
      helpCnt <= '0;
    end else begin
      helpCnt <= helpCnt + 1'b1;
    end
  end

  chk_clear_length: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(busy) |-> ($past(helpCnt) == LAST))
    else $error("RAM clear did not last depth plus one cycles");

  chk_clear_done: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(busy) |-> done)
    else $error("RAM clear end not signalled with busy fall");
endmodule

// ---- verification/frc_link_model.sv ----
// Link-side model: finishes launches, delivers frames and steps slot and buffer state.
`timescale 1ns/1ps
module frc_link_model
  import frc_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         txStart,
  input  wire logic [7:0]   dly,
  input  wire logic         rxGo,
  input  wire logic [1:0]   rxErr,
  input  wire logic         step,
  output logic              txDone,
  output frc_rx_status_t    rxStatus,
  output logic [SLOT_W-1:0] slotCounter,
  output logic [TB_W-1:0]   tbState
);
  logic [7:0] cnt;

  // Each launch ends once, dly cycles after it is seen; frames and steps come on command.
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt         <= 8'h0;
      txDone      <= 1'b0;
      rxStatus    <= '0;
      slotCounter <= '0;
      tbState     <= '0;
    end else begin
      cnt      <= txStart ? dly : (cnt != 8'h0 ? cnt - 8'h1 : cnt);
      txDone   <= (cnt == 8'h1);
      rxStatus <= {rxGo, rxGo & rxErr[1], rxGo & rxErr[0]};
      if (step) begin
        slotCounter <= slotCounter + 11'h1;
        tbState     <= tbState + 5'h3;
      end
    end
  end
endmodule

// ---- verification/tb_frc_ctrl_top.sv ----
// Self-checking bench for the test mode, RAM clear, interrupt and trigger block.
`timescale 1ns/1ps
module tb_frc_ctrl_top
  import frc_pkg::*;
;
  localparam int DEPTH = 16;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [7:0]        regAddr = '0;
  logic [31:0]       regWdata = '0;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic [31:0]       regRdata;
  frc_rx_status_t    rxStatus;
  logic              txDone;
  logic [SLOT_W-1:0] slotCounter;
  logic [TB_W-1:0]   tbState;
  logic              txStart;
  logic [1:0]        txBufIndex;
  logic              loopBackEn;
  logic              asyncTxEn;
  logic [1:0]        testMux;
  logic              ramClearActive;
  logic              irq;
  logic              irqLineZero;
  logic              irqLineOne;
  frc_trig_t         trigBusTwo;
  logic [7:0]        dly = 8'h14;
  logic [1:0]        rxErr = 2'h0;
  logic              rxGo = 1'b0;
  logic              step = 1'b0;
  logic [31:0]       rd;
  int                nFail = 0;
  int                nCompared = 0;
  int                zeroCnt = 0;
  int                oneCnt = 0;
  int                clrCycles = 0;

  always #25 clk = ~clk;

  frc_ctrl_top #(.RAM_DEPTH(DEPTH), .NBUF(4)) dut (.clk(clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .rxStatus(rxStatus), .txDone(txDone),
    .slotCounter(slotCounter), .tbState(tbState), .txStart(txStart),
    .txBufIndex(txBufIndex), .loopBackEn(loopBackEn), .asyncTxEn(asyncTxEn),
    .testMux(testMux), .ramClearActive(ramClearActive), .irq(irq),
    .irqLineZero(irqLineZero), .irqLineOne(irqLineOne), .trigBusTwo(trigBusTwo));

  frc_link_model link (.clk(clk), .sys_rst(sys_rst), .txStart(txStart), .dly(dly),
    .rxGo(rxGo), .rxErr(rxErr), .step(step), .txDone(txDone), .rxStatus(rxStatus),
    .slotCounter(slotCounter), .tbState(tbState));

  // Tallies interrupt pulses and clear-busy cycles outside reset.
  always @(posedge clk) begin
    if (irqLineZero === 1'b1) zeroCnt++;
    if (irqLineOne === 1'b1) oneCnt++;
    if (sys_rst === 1'b0 && ramClearActive === 1'b1) clrCycles++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nFail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // The answer stands only in the cycle after the strobe.
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask

  task automatic finish_test;
    if (nFail == 0 && nCompared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic t_reset_clear;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (DEPTH + 8) @(posedge clk);
    check(clrCycles, DEPTH + 1);
    check(oneCnt, 1);
    rdr(OFS_IRQ_STAT);
    check(rd & 32'h2, 32'h2);
  endtask

  task automatic t_regs;
    logic [7:0] ofs [6] = '{OFS_TEST_ONE, OFS_TEST_TWO, OFS_IRQ_MASK, OFS_CMD, OFS_TX_REQ, 8'h40};
    wr(8'h40, 32'hffffffff);
    foreach (ofs[i]) begin
      rdr(ofs[i]);
      check(rd, 32'h0);
    end
    wr(OFS_TEST_TWO, 32'h4000);
    rdr(OFS_TEST_TWO);
    check(rd & 32'h4000, 32'h0);
  endtask

  task automatic t_modes;
    logic [31:0] v [4] = '{32'h100, 32'h200, 32'h10, 32'h20};
    foreach (v[i]) begin
      wr(OFS_TEST_ONE, v[i]);
      #1;
      check({loopBackEn, asyncTxEn, testMux}, {v[i][8], v[i][9], v[i][5:4]});
      rdr(OFS_TEST_ONE);
      check(rd, v[i]);
    end
  endtask

  task automatic t_ram;
    wr(OFS_IRQ_STAT, 32'h2);
    wr(OFS_TEST_ONE, 32'h11);
    wr(OFS_RAM_ADDR, 32'h3);
    wr(OFS_RAM_DATA, 32'hbeef);
    rdr(OFS_RAM_DATA);
    check(rd, 32'hbeef);
    clrCycles = 0;
    wr(OFS_CMD, {28'h0, CMD_RAM_CLEAR});
    rdr(OFS_MH_STAT);
    check(rd & 32'h80, 32'h80);
    wr(OFS_RAM_DATA, 32'h1234);
    repeat (DEPTH + 8) @(posedge clk);
    check(clrCycles, DEPTH + 1);
    rdr(OFS_MH_STAT);
    check(rd & 32'h80, 32'h0);
    rdr(OFS_RAM_DATA);
    check(rd, 32'h0);
    check(oneCnt, 2);
    wr(OFS_TEST_ONE, 32'h0);
  endtask

  // With race set, the flag clear lands on the edge that takes the finish pulse.
  task automatic run_tx(input logic [1:0] idx, input logic race);
    int n;
    wr(OFS_TX_REQ, {30'h0, idx});
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (txStart !== 1'b1 && n < 10);
    check(txBufIndex, idx);
    if (race === 1'b1) begin
      repeat (dly) @(posedge clk);
      wr(OFS_IRQ_STAT, 32'h1);
    end else begin
      rdr(OFS_TX_PEND);
      check(rd, 32'h1 << idx);
    end
    n = 0;
    do begin
      rdr(OFS_TX_PEND);
      n++;
    end while (rd !== 32'h0 && n < 40);
    check(rd, 32'h0);
  endtask

  task automatic t_tx;
    int n;
    wr(OFS_IRQ_MASK, 32'h1);
    run_tx(2'h2, 1'b0);
    rdr(OFS_IRQ_STAT);
    check(rd & 32'h1, 32'h1);
    check(irq, 1'b1);
    check(zeroCnt, 1);
    wr(OFS_IRQ_STAT, 32'h1);
    rdr(OFS_IRQ_STAT);
    check(rd & 32'h1, 32'h0);
    check(irq, 1'b0);
    run_tx(2'h1, 1'b1);
    rdr(OFS_IRQ_STAT);
    check(rd & 32'h1, 32'h1);
    check(zeroCnt, 2);
    run_tx(2'h3, 1'b0);
    check(zeroCnt, 2);
    wr(OFS_IRQ_MASK, 32'h0);
    // The level output takes the new mask one edge after the write.
    @(posedge clk);
    #1;
    check(irq, 1'b0);
    n = 0;
    do begin
      wr(OFS_IRQ_STAT, 32'h1);
      rdr(OFS_IRQ_STAT);
      n++;
    end while ((rd & 32'h1) !== 32'h0 && n < 4);
    check(rd & 32'h1, 32'h0);
  endtask

  task automatic t_coding;
    logic [1:0] err [3] = '{2'b10, 2'b01, 2'b11};
    logic [1:0] exp [3] = '{CERR_CRC, CERR_FES, CERR_FES};
    wr(OFS_IRQ_MASK, 32'h4);
    foreach (err[i]) begin
      @(posedge clk);
      rxErr <= err[i];
      rxGo  <= 1'b1;
      @(posedge clk);
      rxGo <= 1'b0;
      rdr(OFS_TEST_ONE);
      check(rd[17:16], exp[i]);
    end
    rdr(OFS_IRQ_STAT);
    check(rd & 32'h4, 32'h4);
    check(irq, 1'b1);
    wr(OFS_IRQ_STAT, 32'h4);
    rdr(OFS_IRQ_STAT);
    check(rd & 32'h4, 32'h0);
    check(irq, 1'b0);
  endtask

  // Valid follows a slot step whatever the select; a zero payload is dropped by consumers.
  task automatic t_trig(input logic sel);
    wr(OFS_TRIG_SEL, {31'h0, sel});
    @(posedge clk);
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    @(posedge clk);
    #1;
    check(trigBusTwo.valid, 1'b1);
    check(trigBusTwo.data, sel ? {slotCounter, tbState} : 16'h0);
    @(posedge clk);
    #1;
    check(trigBusTwo.valid, 1'b0);
  endtask

  task automatic t_return;
    wr(OFS_TEST_ONE, 32'h310);
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check({loopBackEn, asyncTxEn, testMux, ramClearActive}, 5'h1);
    repeat (DEPTH + 8) @(posedge clk);
    check(ramClearActive, 1'b0);
  endtask

  // Cuts a hang short.
  initial begin
    repeat (3000) @(posedge clk);
    nFail++;
    finish_test();
  end

  // Main sequence.
  initial begin
    t_reset_clear();
    t_regs();
    t_modes();
    t_ram();
    t_tx();
    t_coding();
    t_trig(1'b0);
    t_trig(1'b1);
    t_return();
    finish_test();
  end
endmodule
